// File: hw/sarc_defines.svh
// Purpose: Shared constants of the converter control and serial output block.
// Assumes: Included by bare name from every file that needs it.
// Notes: The clock counts refer to falling edges of the serial clock.
`ifndef SARC_DEFINES_SVH
`define SARC_DEFINES_SVH

`define SARC_RES_BITS 12
`define SARC_FIFO_DEPTH 4
`define SARC_CYC_FIRST 4'h1
`define SARC_CYC_LAST 4'hd
`define SARC_LSB_LAST 4'hb
`define SARC_TRIAL_RST 12'h800
`define SARC_CODE_ZERO 12'h000

`endif

// File: hw/sarc_pkg.sv
// Purpose: Types of the converter control and serial output block.
// Assumes: sarc_defines.svh is on the include path.
// Notes: States are one-hot with the codes written out.
`include "sarc_defines.svh"
package sarc_pkg;
	typedef enum logic [4:0] {
		ST_SAMPLE = 5'b0_0001,
		ST_HOLD = 5'b0_0010,
		ST_CONVERT = 5'b0_0100,
		ST_LSB = 5'b0_1000,
		ST_PDOWN = 5'b1_0000
	} sarc_state_e;

	typedef struct packed {
		logic lsb_first;
		logic [`SARC_RES_BITS-1:0] code;
	} sarc_res_s;

	typedef struct packed {
		logic data;
		logic oe_n;
	} sarc_pin_s;
endpackage

// File: hw/sarc_fifo.sv
// Purpose: Result FIFO between the converter and the on-chip consumer.
// Assumes: One clock, asynchronous active-high reset.
// Notes: Storage is flip-flops; full and empty come from an occupancy count.
`timescale 1ns/1ns
`include "sarc_defines.svh"
module sarc_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = `SARC_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
	logic [AW:0] cnt_ff, nxt_cnt;
	logic push, pop;

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
	assign out_valid = (cnt_ff != '0);
	assign out_data = mem_ff[rd_ff];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		nxt_wr = push ? ptr_inc(wr_ff) : wr_ff;
		nxt_rd = pop ? ptr_inc(rd_ff) : rd_ff;
		nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else begin
			wr_ff <= nxt_wr;
			rd_ff <= nxt_rd;
			cnt_ff <= nxt_cnt;
		end
	end

	// Data words need no reset; occupancy guards every read.
	for (genvar i = 0; i < DEPTH; i++) begin : g_slot
		always_ff @(posedge clk) begin
			if (push && wr_ff == AW'(i)) begin
				mem_ff[i] <= in_data;
			end
		end
	end
endmodule // sarc_fifo

// File: hw/sarc_ctrl.sv
// Purpose: Conversion control and serial data output of a 12-bit successive-approximation converter.
// Assumes: Strobe and serial clock are synchronous to clk and slower than it; comparator settles in one cycle.
// Notes: Serial clock edges are found by comparing with the previous sample; results also go to a FIFO.
`timescale 1ns/1ns
`include "sarc_defines.svh"
// Behaviour
// RULE_01 - A strobe that rose during the conversion and falls in the 13th clock selects LSB-first readout.
// RULE_02 - LSB-first readout resends the result on the next 11 clocks, low bits first, up to the top bit.
// RULE_03 - LSB-first readout powers down during the 13th clock and resumes when the strobe rises.
// RULE_04 - A conversion can be short-cycled, stopping at once before all twelve bits are decided.
// RULE_05 - Strobe high then low before the 13th clock aborts; low inside the 13th clock selects LSB-first.
// RULE_06 - The data output goes to high impedance as soon as the strobe falls.
// RULE_07 - A host that short-cycles latches the current bit before it lowers the strobe.
// RULE_08 - The result is straight unsigned binary, all zeros for zero input.
// RULE_09 - The sample-and-hold goes to hold when the strobe falls.
// RULE_10 - The host starts clocking soon enough after the strobe falls to keep droop small.
// RULE_11 - The host keeps each serial clock period within its maximum during a conversion.
// RULE_12 - An SPI-style host drives the strobe from a port pin, supplies the clock and samples data.
// RULE_13 - The host starts the clock within 5 us of the strobe falling.
// RULE_14 - A strobe still low when the 13th clock starts causes power-down until the strobe rises.
// RULE_15 - The host keeps the strobe high for at least 350 ns before the next conversion.
// RULE_16 - The first clock of a conversion drives the data output low out of high impedance.
// RULE_17 - Normal readout sends bits most significant first, ending with the lowest bit in the 13th clock.
module sarc_ctrl #(
	parameter int RES_BITS = `SARC_RES_BITS,
	parameter int FIFO_DEPTH = `SARC_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Host pins
	input wire logic conversion_strobe,
	input wire logic serial_clk,
	output sarc_pkg::sarc_pin_s data_pin,
	// Analog core
	input wire logic comp_keep,
	output logic [RES_BITS-1:0] dac_trial,
	output logic hold_mode,
	output logic power_down,
	// Result stream
	output logic res_valid,
	input wire logic res_ready,
	output sarc_pkg::sarc_res_s res_data
);
	import sarc_pkg::*;

	sarc_state_e state_ff, nxt_state;
	logic [3:0] cyc_ff, nxt_cyc;
	logic [RES_BITS-1:0] code_ff, nxt_code;
	logic dout_ff, nxt_dout, oe_n_ff, nxt_oe_n;
	logic armed_ff, nxt_armed, pd_ff, nxt_pd;
	logic conversion_strobe_q_ff, sclk_q_ff;
	logic conversion_strobe_fall, conversion_strobe_rise, sclk_fall;
	logic push, fifo_ready;
	sarc_res_s push_word;

	// Bit decided at the start of conversion clock c is bit 13-c.
	function automatic logic [3:0] bit_at(input logic [3:0] c);
		bit_at = `SARC_CYC_LAST - c;
	endfunction

	assign conversion_strobe_fall = conversion_strobe_q_ff && !conversion_strobe;
	assign conversion_strobe_rise = !conversion_strobe_q_ff && conversion_strobe;
	assign sclk_fall = sclk_q_ff && !serial_clk;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			conversion_strobe_q_ff <= 1'b1;
			sclk_q_ff <= 1'b0;
		end else begin
			conversion_strobe_q_ff <= conversion_strobe;
			sclk_q_ff <= serial_clk;
		end
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_cyc = cyc_ff;
		nxt_code = code_ff;
		nxt_dout = dout_ff;
		nxt_oe_n = oe_n_ff;
		nxt_armed = armed_ff;
		nxt_pd = pd_ff;
		push = 1'b0;
		push_word = '{lsb_first: 1'b0, code: code_ff};
		if (conversion_strobe_fall) begin
			nxt_oe_n = 1'b1; // [RULE_06]
		end
		if (conversion_strobe_rise) begin
			nxt_pd = 1'b0; // [RULE_03] [RULE_14]
		end
		case (state_ff)
			ST_SAMPLE: begin
				if (conversion_strobe_fall) begin
					nxt_state = ST_HOLD; // [RULE_09]
				end
			end
			ST_HOLD: begin
				if (conversion_strobe_rise) begin
					nxt_state = ST_SAMPLE;
				end else if (sclk_fall && fifo_ready) begin
					// A full result FIFO holds off the start so no finished result is lost.
					nxt_state = ST_CONVERT;
					nxt_cyc = `SARC_CYC_FIRST;
					nxt_code = `SARC_TRIAL_RST;
					nxt_armed = 1'b0;
					nxt_dout = 1'b0; // [RULE_16]
					nxt_oe_n = 1'b0; // [RULE_16]
				end
			end
			ST_CONVERT: begin
				if (conversion_strobe_rise) begin
					nxt_armed = 1'b1;
				end
				if (conversion_strobe_fall && armed_ff && cyc_ff != `SARC_CYC_LAST) begin
					nxt_state = ST_HOLD; // [RULE_04] [RULE_05]
				end else if (conversion_strobe_fall && armed_ff) begin
					nxt_state = ST_LSB; // [RULE_01] [RULE_05]
					nxt_cyc = 4'h0;
					nxt_pd = 1'b1; // [RULE_03]
					push = 1'b1;
					push_word.lsb_first = 1'b1;
				end else if (sclk_fall && cyc_ff == `SARC_CYC_LAST) begin
					push = 1'b1;
					nxt_oe_n = 1'b1;
					nxt_state = pd_ff ? ST_PDOWN : ST_SAMPLE;
				end else if (sclk_fall) begin
					// Straight binary: a kept trial bit is a one in the output code.
					nxt_cyc = cyc_ff + 4'h1;
					nxt_code[bit_at(cyc_ff + 4'h1)] = comp_keep; // [RULE_08]
					if (bit_at(cyc_ff + 4'h1) != 4'h0) begin
						nxt_code[bit_at(cyc_ff + 4'h1) - 4'h1] = 1'b1;
					end
					nxt_dout = comp_keep; // [RULE_17]
					if (cyc_ff + 4'h1 == `SARC_CYC_LAST && !conversion_strobe) begin
						nxt_pd = 1'b1; // [RULE_14]
					end
				end
			end
			ST_LSB: begin
				if (conversion_strobe_rise) begin
					nxt_state = ST_SAMPLE; // [RULE_03]
					nxt_oe_n = 1'b1;
				end else if (sclk_fall && cyc_ff == `SARC_LSB_LAST) begin
					nxt_state = ST_PDOWN;
					nxt_oe_n = 1'b1;
				end else if (sclk_fall) begin
					nxt_cyc = cyc_ff + 4'h1;
					nxt_dout = code_ff[cyc_ff + 4'h1]; // [RULE_02]
					nxt_oe_n = 1'b0;
				end
			end
			ST_PDOWN: begin
				if (conversion_strobe_rise) begin
					nxt_state = ST_SAMPLE; // [RULE_14]
				end
			end
			default: begin
				nxt_state = ST_SAMPLE;
				nxt_oe_n = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff <= ST_SAMPLE;
			cyc_ff <= 4'h0;
			code_ff <= `SARC_CODE_ZERO;
			dout_ff <= 1'b0;
			oe_n_ff <= 1'b1;
			armed_ff <= 1'b0;
			pd_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cyc_ff <= nxt_cyc;
			code_ff <= nxt_code;
			dout_ff <= nxt_dout;
			oe_n_ff <= nxt_oe_n;
			armed_ff <= nxt_armed;
			pd_ff <= nxt_pd;
		end
	end

	assign data_pin = '{data: dout_ff, oe_n: oe_n_ff};
	assign dac_trial = code_ff;
	assign hold_mode = (state_ff != ST_SAMPLE); // [RULE_09]
	assign power_down = pd_ff;

	sarc_fifo #(
		.WIDTH($bits(sarc_res_s)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.in_valid(push),
		.in_ready(fifo_ready),
		.in_data(push_word),
		.out_valid(res_valid),
		.out_ready(res_ready),
		.out_data(res_data)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_lsb_entry: assert property ((state_ff == ST_CONVERT) && cyc_ff == `SARC_CYC_LAST && armed_ff && conversion_strobe_fall
		|=> state_ff == ST_LSB && pd_ff && oe_n_ff) // [RULE_01]
		else $error("LSB-first readout not entered");
	chk_lsb_bits: assert property ((state_ff == ST_LSB) && sclk_fall && !conversion_strobe_rise && cyc_ff != `SARC_LSB_LAST
		|=> !oe_n_ff && dout_ff == code_ff[cyc_ff]) // [RULE_02]
		else $error("LSB-first bit order wrong");
	chk_lsb_span: assert property ((state_ff == ST_LSB) |-> cyc_ff <= `SARC_LSB_LAST) // [RULE_02]
		else $error("LSB-first readout ran too long");
	// A rise inside the last conversion clock arms and clears power-down; the frame still has to end first.
	chk_pd_wake: assert property (pd_ff && conversion_strobe_rise
		|=> !pd_ff && ($past(state_ff) == ST_CONVERT || state_ff == ST_SAMPLE)) // [RULE_03]
		else $error("Power-down did not end on strobe rise");
	chk_short_abort: assert property ((state_ff == ST_CONVERT) && armed_ff && conversion_strobe_fall && cyc_ff < `SARC_CYC_LAST
		|=> state_ff == ST_HOLD && oe_n_ff && !push) // [RULE_04] [RULE_05]
		else $error("Short-cycle did not abort");
	chk_fall_hiz: assert property (conversion_strobe_fall |=> oe_n_ff) // [RULE_06]
		else $error("Data not released on strobe fall");
	chk_msb_bits: assert property ((state_ff == ST_CONVERT) && sclk_fall && !conversion_strobe_fall && cyc_ff < `SARC_CYC_LAST
		|=> dout_ff == $past(comp_keep) && code_ff[bit_at(cyc_ff)] == $past(comp_keep)) // [RULE_17] [RULE_08]
		else $error("Decided bit not driven");
	chk_hold_fall: assert property (conversion_strobe_fall |=> hold_mode) // [RULE_09]
		else $error("Hold not entered on strobe fall");
	chk_pd_low: assert property ((state_ff == ST_CONVERT) && sclk_fall && !conversion_strobe_fall && cyc_ff == 4'hc
		&& !conversion_strobe |=> pd_ff ##1 (pd_ff || $past(conversion_strobe_rise))) // [RULE_14]
		else $error("Power-down not entered at 13th clock");
	chk_first_low: assert property ((state_ff == ST_HOLD) && sclk_fall && fifo_ready && !conversion_strobe_rise
		|=> !oe_n_ff && !dout_ff && cyc_ff == `SARC_CYC_FIRST) // [RULE_16]
		else $error("First clock did not drive low");

	cov_normal: cover property ((state_ff == ST_CONVERT) && sclk_fall && cyc_ff == `SARC_CYC_LAST && !pd_ff);
	cov_pdown: cover property ((state_ff == ST_CONVERT) ##1 (state_ff == ST_PDOWN));
	cov_lsb: cover property ((state_ff == ST_LSB) && sclk_fall && cyc_ff == `SARC_LSB_LAST);
	cov_short: cover property ((state_ff == ST_CONVERT) && armed_ff && conversion_strobe_fall && cyc_ff < `SARC_CYC_LAST);
	cov_stall: cover property ((state_ff == ST_HOLD) && sclk_fall && !fifo_ready);
endmodule // sarc_ctrl

// File: bench/sarc_host_model.sv
// Purpose: Host serial port that drives the strobe and serial clock and samples the data line.
// Assumes: The data line has a pull-up, so a released line reads high.
// Notes: Each serial clock lasts six clk cycles, eight where the strobe is lowered; a bit is taken just before the line is clocked again.
`timescale 1ns/1ns
module sarc_host_model (
	// Clock
	input wire logic clk,
	// Pins
	output logic conversion_strobe,
	output logic serial_clk,
	input wire sarc_pkg::sarc_pin_s data_pin
);
	import sarc_pkg::*;
	logic line;
	logic cap_bit [0:24];
	logic cap_oe [0:24];
	logic cap_hz;
	// A stale bit must not pass for a driven one, so the pull-up wins when released.
	assign line = data_pin.oe_n ? 1'b1 : data_pin.data;
	initial begin
		conversion_strobe = 1'b1;
		serial_clk = 1'b1;
	end
	task automatic set_strobe(input logic v);
		@(posedge clk) conversion_strobe <= v;
		repeat (3) @(posedge clk);
		#1;
	endtask
	// Mode 0 power-down, 1 LSB-first repeat, 2 short cycle, 3 strobe high at the last clock.
	task automatic run(input int mode);
		int n;
		n = (mode == 1) ? 25 : (mode == 2) ? 8 : 14;
		for (int i = 0; i < n; i++) begin
			@(posedge clk) serial_clk <= 1'b0;
			repeat (3) @(posedge clk);
			#1;
			cap_bit[i] = line;
			cap_oe[i] = data_pin.oe_n;
			@(posedge clk) serial_clk <= 1'b1;
			if ((mode == 1 && i == 5) || (mode == 2 && i == 3) || (mode == 3 && i == 11))
				conversion_strobe <= 1'b1;
			if ((mode == 1 && i == 12) || (mode == 2 && i == 7)) begin
				conversion_strobe <= 1'b0;
				repeat (2) @(posedge clk);
				#1;
				cap_hz = data_pin.oe_n;
			end
			@(posedge clk);
		end
	endtask
endmodule // sarc_host_model

// File: bench/sar_adc_serial_output_control_tb_top.sv
// Purpose: Self-checking bench of the conversion control and serial output block.
// Assumes: The comparator is modelled as an ideal compare of the input code with the trial code.
// Notes: Results are checked against a queue of expected words as they leave the FIFO.
`timescale 1ns/1ns
`include "sarc_defines.svh"
module sar_adc_serial_output_control_tb_top;
	import sarc_pkg::*;
	logic clk, rst, conversion_strobe, serial_clk, comp_keep, res_ready, drain_en;
	logic hold_mode, power_down, res_valid;
	logic [11:0] vin;
	logic [11:0] dac_trial;
	sarc_pin_s data_pin;
	sarc_res_s res_data;
	int failures, total_checks;
	logic [12:0] exp_q [$];
	assign comp_keep = (vin >= dac_trial);
	sarc_ctrl dut (.clk(clk), .rst(rst), .conversion_strobe(conversion_strobe), .serial_clk(serial_clk),
		.data_pin(data_pin), .comp_keep(comp_keep), .dac_trial(dac_trial), .hold_mode(hold_mode),
		.power_down(power_down), .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));
	sarc_host_model host (.clk(clk), .conversion_strobe(conversion_strobe), .serial_clk(serial_clk),
		.data_pin(data_pin));
	task automatic chk1(input string name, input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %b seen %b", name, e, g);
		end
	endtask
	task automatic chk13(input string name, input logic [12:0] e, input logic [12:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, e, g);
		end
	endtask
	task automatic summarize();
		if (failures == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check_frame(input int mode, input logic [11:0] code);
		int last;
		last = (mode == 2) ? 8 : 13;
		chk1("start bit", 1'b0, host.cap_bit[0]);
		for (int k = 1; k < last; k++)
			chk1("msb bit", code[12-k], host.cap_bit[k]);
		if (mode == 1 || mode == 2)
			chk1("hiz on fall", 1'b1, host.cap_hz);
		if (mode == 1) begin
			for (int k = 1; k < 12; k++)
				chk1("lsb bit", code[k], host.cap_bit[12+k]);
			chk1("lsb end", 1'b1, host.cap_oe[24]);
		end
		if (mode == 0 || mode == 3)
			chk1("frame end", 1'b1, host.cap_oe[13]);
		if (mode != 2) begin
			chk13("trial code", {1'b0, code}, {1'b0, dac_trial});
			chk1("power down", logic'(mode != 3), power_down);
		end
	endtask
	task automatic do_frame(input int mode, input logic [11:0] v);
		@(posedge clk) vin <= v;
		host.set_strobe(1'b1);
		chk1("wake", 1'b0, power_down);
		chk1("sample", 1'b0, hold_mode);
		repeat (37) @(posedge clk);
		host.set_strobe(1'b0);
		chk1("hold", 1'b1, hold_mode);
		chk1("idle hiz", 1'b1, data_pin.oe_n);
		// The result may leave the FIFO before the frame ends, so it is expected up front.
		if (mode != 2)
			exp_q.push_back({logic'(mode == 1), v});
		host.run(mode);
		check_frame(mode, v);
		if (mode == 2) begin
			exp_q.push_back({1'b0, v});
			host.run(0);
			check_frame(0, v);
		end
	endtask
	always @(posedge clk) begin
		res_ready <= drain_en & 1'($urandom);
		if (!rst && res_valid === 1'b1 && res_ready === 1'b1)
			chk13("result", (exp_q.size() > 0) ? exp_q.pop_front() : 13'bx, res_data);
	end
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		summarize();
	end
	initial begin
		rst = 1'b1;
		res_ready = 1'b0;
		drain_en = 1'b0;
		vin = 12'h000;
		failures = 0;
		total_checks = 0;
		void'($urandom(32'h16af));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		do_frame(0, 12'h000);
		do_frame(1, 12'hfff);
		do_frame(3, 12'($urandom));
		do_frame(2, 12'($urandom));
		chk1("fifo holds", 1'b1, res_valid);
		@(posedge clk) drain_en <= 1'b1;
		for (int i = 0; i < 8; i++)
			do_frame(int'($urandom % 4), 12'($urandom));
		for (int t = 0; t < 200 && exp_q.size() > 0; t++)
			@(posedge clk);
		#1;
		chk1("fifo empty", 1'b0, res_valid);
		chk1("queue drained", 1'b1, logic'(exp_q.size() == 0));
		summarize();
	end
endmodule // sar_adc_serial_output_control_tb_top
